// File: shared/dac_ctrl_regs.vh
// constants for the serial dac word receiver and power mode control
`ifndef DAC_CTRL_REGS_VH
`define DAC_CTRL_REGS_VH
`define WORD_BITS          16
`define CODE_BITS          12
`define CODE_LSB_POS       0
`define CODE_MSB_POS       11
`define WORD_BIT_12_POS    12
`define WORD_BIT_13_POS    13
`define BIT_COUNT_W        5
`define CODE_RESET         12'h000
`define MODE_NORMAL        2'h0
`define MODE_PD_1K         2'h1
`define MODE_PD_100K       2'h2
`define MODE_PD_HIZ        2'h3
`define SYNC_HIGH_MIN_NS   33
`define CLK_PERIOD_NS      100
`define SYNC_HIGH_MIN_CYC  ((`SYNC_HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: rtl/pin_sync.v
// two-flop synchroniser for a group of input pins
module pin_sync #(
  parameter WIDTH = 3
) (
  input  wire             clk_sys,
  input  wire             nrst,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out
);
  reg [WIDTH-1:0] stage1_reg;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      stage1_reg <= {WIDTH{1'b1}};
      pin_out    <= {WIDTH{1'b1}};
    end else begin
      stage1_reg <= pin_in;
      pin_out    <= stage1_reg;
    end
  end
endmodule

// File: rtl/dac_serial_word_and_power_mode_ctrl.v
// serial word receiver, dac code register and power mode control
`include "dac_ctrl_regs.vh"
module dac_serial_word_and_power_mode_ctrl #(
  parameter WORD_BITS = `WORD_BITS,
  parameter CODE_BITS = `CODE_BITS
) (
  input  wire                 clk_sys,
  input  wire                 nrst,
  input  wire                 sclk,
  input  wire                 sync_n,
  input  wire                 din,
  output reg  [CODE_BITS-1:0] dac_code,
  output reg  [1:0]           power_mode,
  output reg                  amp_enable,
  output reg                  term_1k_en,
  output reg                  term_100k_en,
  output reg                  word_done,
  output reg                  word_abort
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE = 3'b100;
  localparam integer LAST_COUNT = WORD_BITS - 1;

  wire [2:0] pins_s;
  wire       sclk_s;
  wire       sync_n_s;
  wire       din_s;

  reg  [2:0]             state_reg;
  reg  [2:0]             state_next;
  reg                    sclk_d_reg;
  reg                    sync_d_reg;
  reg  [WORD_BITS-1:0]   shift_reg;
  reg  [WORD_BITS-1:0]   shift_next;
  reg  [`BIT_COUNT_W-1:0] count_reg;
  reg  [`BIT_COUNT_W-1:0] count_next;
  reg  [CODE_BITS-1:0]   code_next;
  reg  [1:0]             mode_next;
  reg                    done_next;
  reg                    abort_next;

  // power stage switches for a mode: amplifier, 1k, 100k
  function [2:0] mode_enables;
    input [1:0] mode;
    begin
      mode_enables = {mode == `MODE_NORMAL, mode == `MODE_PD_1K, mode == `MODE_PD_100K};
    end
  endfunction

  // one serial bit into the shifter, msb first
  function [WORD_BITS-1:0] shift_in;
    input [WORD_BITS-1:0] word;
    input                 bit_in;
    begin
      shift_in = {word[WORD_BITS-2:0], bit_in};
    end
  endfunction

  // mode field of a received word
  function [1:0] mode_field;
    input [WORD_BITS-1:0] word;
    begin
      mode_field = {word[`WORD_BIT_13_POS], word[`WORD_BIT_12_POS]};
    end
  endfunction

  wire sclk_fall = sclk_d_reg & ~sclk_s;
  wire sync_fall = sync_d_reg & ~sync_n_s;
  wire sync_rise = ~sync_d_reg & sync_n_s;

  pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin_in  ({sclk, sync_n, din}),
    .pin_out (pins_s)
  );

  assign sclk_s   = pins_s[2];
  assign sync_n_s = pins_s[1];
  assign din_s    = pins_s[0];

  // frame sequencing, shifting and counting
  always @* begin
    state_next = state_reg;
    shift_next = shift_reg;
    count_next = count_reg;
    done_next  = 1'b0;
    abort_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (sync_fall) begin
          state_next = ST_SHIFT;
          shift_next = {WORD_BITS{1'b0}};
          count_next = {`BIT_COUNT_W{1'b0}};
        end
      end
      ST_SHIFT: begin
        if (sync_n_s) begin
          state_next = ST_IDLE;
          shift_next = {WORD_BITS{1'b0}};
          count_next = {`BIT_COUNT_W{1'b0}};
          abort_next = 1'b1;
        end else if (sclk_fall) begin
          shift_next = shift_in(shift_reg, din_s);
          count_next = count_reg + 1'b1;
          if (count_reg == LAST_COUNT) begin
            state_next = ST_DONE;
            done_next  = 1'b1;
          end
        end
      end
      ST_DONE: begin
        if (sync_n_s) begin
          state_next = ST_IDLE;
          shift_next = {WORD_BITS{1'b0}};
          count_next = {`BIT_COUNT_W{1'b0}};
        end
      end
      default: begin
        state_next = ST_IDLE;
        shift_next = {WORD_BITS{1'b0}};
        count_next = {`BIT_COUNT_W{1'b0}};
      end
    endcase
  end

  // word fields, applied only by an executed word
  always @* begin
    code_next = dac_code;
    mode_next = power_mode;
    if (done_next) begin
      code_next = shift_next[`CODE_MSB_POS:`CODE_LSB_POS];
      mode_next = mode_field(shift_next);
    end
  end

  // pin edge history
  always @(posedge clk_sys) begin
    if (!nrst) begin
      sclk_d_reg <= 1'b1;
      sync_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      sync_d_reg <= sync_n_s;
    end
  end

  // frame state, shifter and bit counter
  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      shift_reg <= {WORD_BITS{1'b0}};
      count_reg <= {`BIT_COUNT_W{1'b0}};
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
    end
  end

  // held code and mode
  always @(posedge clk_sys) begin
    if (!nrst) begin
      dac_code   <= `CODE_RESET;
      power_mode <= `MODE_NORMAL;
    end else begin
      dac_code   <= code_next;
      power_mode <= mode_next;
    end
  end

  // output stage switches
  always @(posedge clk_sys) begin
    if (!nrst) begin
      {amp_enable, term_1k_en, term_100k_en} <= mode_enables(`MODE_NORMAL);
    end else begin
      {amp_enable, term_1k_en, term_100k_en} <= mode_enables(mode_next);
    end
  end

  // execution pulse
  always @(posedge clk_sys) begin
    if (!nrst) begin
      word_done <= 1'b0;
    end else begin
      word_done <= done_next;
    end
  end

  // abort pulse
  always @(posedge clk_sys) begin
    if (!nrst) begin
      word_abort <= 1'b0;
    end else begin
      word_abort <= abort_next;
    end
  end
endmodule

// File: sim/host_model.sv
// host serial master model driving frame, clock and data
module host_model (
  input  wire  clk_sys,
  output logic sclk,
  output logic sync_n,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic send(input logic [15:0] w, input int n);
    sync_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == 8)
        repeat (2) half();
      half();
      sclk <= 1'b1;
      din <= (i < 16) ? w[15-i] : ~din;
      half();
      sclk <= 1'b0;
    end
    half();
    sync_n <= 1'b1;
    din <= ~din;
    repeat (10) @(posedge clk_sys);
  endtask
endmodule

// File: sim/dac_ctrl_checker.sv
// port assertions for the serial dac word receiver
module dac_ctrl_checker #(
  parameter CODE_BITS = 12
) (
  input wire                 clk_sys,
  input wire                 nrst,
  input wire                 sync_n,
  input wire [CODE_BITS-1:0] dac_code,
  input wire [1:0]           power_mode,
  input wire                 amp_enable,
  input wire                 term_1k_en,
  input wire                 term_100k_en,
  input wire                 word_done,
  input wire                 word_abort
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chk_reset_zero: assert property ($rose(nrst) |-> dac_code == 0 && power_mode == 0)
    else $error("not zero after reset");
  chk_code_hold: assert property ($changed(dac_code) |-> word_done)
    else $error("code changed without word");
  chk_mode_hold: assert property ($changed(power_mode) |-> word_done)
    else $error("mode changed without word");
  chk_amp_mode: assert property (amp_enable == (power_mode == 2'h0))
    else $error("amplifier enable wrong");
  chk_term_low: assert property (term_1k_en == (power_mode == 2'h1))
    else $error("1k termination wrong");
  chk_term_high: assert property (term_100k_en == (power_mode == 2'h2))
    else $error("100k termination wrong");
  chk_done_pulse: assert property (word_done |=> !word_done)
    else $error("done longer than one cycle");
  chk_abort_sync: assert property (word_abort |-> $past(sync_n, 3) && !word_done)
    else $error("abort without frame high");
  chk_done_frame: assert property (word_done |-> !$past(sync_n, 4))
    else $error("done outside a frame");
endmodule
bind dac_serial_word_and_power_mode_ctrl dac_ctrl_checker #(.CODE_BITS(CODE_BITS)) chk_i (
  .clk_sys(clk_sys), .nrst(nrst), .sync_n(sync_n), .dac_code(dac_code),
  .power_mode(power_mode), .amp_enable(amp_enable), .term_1k_en(term_1k_en),
  .term_100k_en(term_100k_en), .word_done(word_done), .word_abort(word_abort));

// File: sim/testbench.sv
// self-checking bench for the serial dac word receiver
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  wire         sclk, sync_n, din, amp_enable, term_1k_en, term_100k_en, word_done, word_abort;
  wire  [11:0] dac_code;
  wire  [1:0]  power_mode;
  int          errors = 0;
  int          checked = 0;
  int          aborts = 0;
  int          aborts_exp = 0;
  logic [15:0] w;
  logic [11:0] code_exp = 12'h000;
  logic [1:0]  mode_exp = 2'h0;
  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
    if (word_abort === 1'b1)
      aborts++;
  host_model host (.clk_sys(clk_sys), .sclk(sclk), .sync_n(sync_n), .din(din));
  dac_serial_word_and_power_mode_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk),
    .sync_n(sync_n), .din(din), .dac_code(dac_code), .power_mode(power_mode),
    .amp_enable(amp_enable), .term_1k_en(term_1k_en), .term_100k_en(term_100k_en),
    .word_done(word_done), .word_abort(word_abort));
  function automatic logic [2:0] enables(input logic [1:0] m);
    return {m == 2'h0, m == 2'h1, m == 2'h2};
  endfunction
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_outs();
    chk("code", dac_code, code_exp);
    chk("mode", 12'(power_mode), 12'(mode_exp));
    chk("enables", 12'({amp_enable, term_1k_en, term_100k_en}), 12'(enables(mode_exp)));
  endtask
  task automatic wait_ev(input logic ab);
    int k;
    for (k = 0; k < 400 && word_done !== 1'b1 && word_abort !== 1'b1; k++)
      @(negedge clk_sys);
    if (k == 400) begin
      errors++;
      results();
    end else begin
      chk("abort", 12'(word_abort), 12'(ab));
      chk("done", 12'(word_done), 12'(!ab));
      chk_outs();
    end
  endtask
  task automatic frame(input logic [15:0] v, input int n);
    if (n >= 16) begin
      code_exp = v[11:0];
      mode_exp = v[13:12];
    end else begin
      aborts_exp++;
    end
    fork
      host.send(v, n);
      wait_ev(n < 16);
    join
    chk("aborts", 12'(aborts), 12'(aborts_exp));
    chk_outs();
  endtask
  initial begin
    void'($urandom(92));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_outs();
    for (int i = 0; i < 12; i++) begin
      w = 16'($urandom);
      if (i < 4)
        w[13:12] = i[1:0];
      frame(w, (i % 3 == 2) ? 32 : 16);
      frame(16'($urandom), (i == 0) ? 15 : $urandom_range(14, 1));
    end
    // mid-run reset clears code and mode
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    code_exp = 12'h000;
    mode_exp = 2'h0;
    repeat (4) @(posedge clk_sys);
    chk_outs();
    frame(16'($urandom), 9);
    frame(16'hfedc, 16);
    results();
  end
endmodule
